// File: inc/ssem_pkg.sv
`default_nettype none
package ssem_pkg;
    // register byte addresses
    localparam logic [4:0] SSEM_ADDR_MODE    = 5'h00;
    localparam logic [4:0] SSEM_ADDR_RATE    = 5'h04;
    localparam logic [4:0] SSEM_ADDR_CTRL    = 5'h08;
    localparam logic [4:0] SSEM_ADDR_TXDATA  = 5'h0c;
    localparam logic [4:0] SSEM_ADDR_STATUS  = 5'h10;
    localparam logic [4:0] SSEM_ADDR_RXDATA  = 5'h14;
    // mode register fields
    localparam int SSEM_MODE_SYNC_BIT   = 7;
    localparam int SSEM_MODE_CHR_BIT    = 6;
    localparam int SSEM_MODE_PAR_BIT    = 5;
    localparam int SSEM_MODE_ODD_BIT    = 4;
    localparam int SSEM_MODE_STOP_BIT   = 3;
    localparam int SSEM_MODE_CKS_LSB    = 0;
    // control register fields
    localparam int SSEM_CTRL_TIE_BIT    = 7;
    localparam int SSEM_CTRL_RIE_BIT    = 6;
    localparam int SSEM_CTRL_TX_BIT     = 5;
    localparam int SSEM_CTRL_RX_BIT     = 4;
    localparam int SSEM_CTRL_RX_FAULT_IRQ_ON_BIT   = 3;
    localparam int SSEM_CTRL_CKE_LSB    = 0;
    // writable masks: upper byte and bit 2 reserved
    localparam logic [15:0] SSEM_MODE_MASK = 16'h00fb;
    localparam logic [15:0] SSEM_CTRL_MASK = 16'h00fb;
    // reset values
    localparam logic [15:0] SSEM_MODE_RESET = 16'h0000;
    localparam logic [15:0] SSEM_CTRL_RESET = 16'h0000;
    localparam logic [7:0]  SSEM_RATE_RESET = 8'hff;
    // status bits
    localparam int SSEM_STAT_TXEMPTY_BIT = 0;
    localparam int SSEM_STAT_RXFULL_BIT  = 1;
    localparam int SSEM_STAT_OVERRUN_BIT = 2;
    localparam int SSEM_STAT_BUSY_BIT    = 3;
    localparam int SSEM_BYTE_BITS        = 8;
    localparam logic [1:0] SSEM_RESP_OKAY   = 2'b00;
    localparam logic [1:0] SSEM_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// File: hw/ssem_rate_gen.sv
`default_nettype none
module ssem_rate_gen
    import ssem_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic [1:0] prescale_sel,
    input  wire logic [7:0] divisor,
    output logic            tick
);
    logic [5:0] pre_reg;
    logic [5:0] pre_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;
    logic       pre_hit;

    // prescale 1, 4, 16, 64 of the peripheral clock
    always_comb begin
        case (prescale_sel)
            2'b00:   pre_hit = 1'b1;
            2'b01:   pre_hit = (pre_reg[1:0] == 2'h3);
            2'b10:   pre_hit = (pre_reg[3:0] == 4'hf);
            default: pre_hit = (pre_reg == 6'h3f);
        endcase
        pre_next  = run ? pre_reg + 6'h01 : 6'h00;
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = 8'h00;
        end else if (pre_hit) begin
            if (cnt_reg >= divisor) begin
                cnt_next  = 8'h00;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg  <= 6'h00;
            cnt_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

// File: hw/ssem_top.sv
// Notes on behaviour
// - channel shifts both directions, internal clock
// - bytes shift most significant bit first
// - sync mode bit set selects synchronous
// - synchronous characters are always eight bits
// - no parity added or checked
// - parity select and stop ignored
// - reserved mode/control bits read zero
// - clock config 00 internal, pin ignored
// - received byte in receive data 7:0
// - written byte shifts out next
// - prescale field picks divided clock
// - bit-rate register sets serial speed
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module ssem_top
    import ssem_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             txd,
    input  wire logic        rxd
);
    typedef enum logic [1:0] {
        SSEM_IDLE = 2'b00,
        SSEM_LOW  = 2'b01,
        SSEM_HIGH = 2'b10
    } ssem_state_t;

    logic [15:0] mode_reg, mode_next;
    logic [15:0] ctrl_reg, ctrl_next;
    logic [7:0]  rate_reg, rate_next;
    logic [7:0]  txbuf_reg, txbuf_next;
    logic        txfull_reg, txfull_next;
    logic [7:0]  rxbuf_reg, rxbuf_next;
    logic        rxfull_reg, rxfull_next;
    logic        ovr_reg, ovr_next;
    ssem_state_t st_reg, st_next;
    logic [7:0]  sh_reg, sh_next;
    logic [7:0]  rsh_reg, rsh_next;
    logic [2:0]  bit_reg, bit_next;
    logic        sck_reg, sck_next;
    logic        txd_reg, txd_next;
    logic        aw_reg, aw_next;
    logic [4:0]  awa_reg, awa_next;
    logic        w_reg, w_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        bv_reg, bv_next;
    logic [1:0]  br_reg, br_next;
    logic        rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0]  rr_reg, rr_next;
    logic        awrdy_reg, awrdy_next;
    logic        wrdy_reg, wrdy_next;
    logic        ardy_reg, ardy_next;
    logic        tick;
    logic        sync_mode, tx_path_on, rx_path_on, int_clock;
    logic        do_write, do_read, rx_take;

    // sync mode bit, plus internal clock config 00; pin clock unused
    assign sync_mode  = mode_reg[SSEM_MODE_SYNC_BIT];
    assign int_clock  = (ctrl_reg[SSEM_CTRL_CKE_LSB +: 2] == 2'b00);
    assign tx_path_on = ctrl_reg[SSEM_CTRL_TX_BIT];
    assign rx_path_on = ctrl_reg[SSEM_CTRL_RX_BIT];

    ssem_rate_gen i_ssem_rate_gen (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (st_reg != SSEM_IDLE),
        .prescale_sel (mode_reg[SSEM_MODE_CKS_LSB +: 2]),
        .divisor      (rate_reg),
        .tick         (tick)
    );

    function automatic logic [15:0] ssem_merge(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        return v & m;
    endfunction

    assign do_write = aw_reg && w_reg && !bv_reg;
    assign do_read  = s_axi_arvalid && ardy_reg;
    assign rx_take  = do_read && (s_axi_araddr == SSEM_ADDR_RXDATA);

    // bus side
    always_comb begin
        aw_next   = aw_reg;
        awa_next  = awa_reg;
        w_next    = w_reg;
        wd_next   = wd_reg;
        ws_next   = ws_reg;
        bv_next   = bv_reg;
        br_next   = br_reg;
        rv_next   = rv_reg;
        rd_next   = rd_reg;
        rr_next   = rr_reg;
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        rate_next = rate_reg;
        if (s_axi_awvalid && awrdy_reg) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_reg) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            br_next = SSEM_RESP_OKAY;
            case (awa_reg)
                SSEM_ADDR_MODE: mode_next = ssem_merge(mode_reg, wd_reg, ws_reg, SSEM_MODE_MASK);
                SSEM_ADDR_CTRL: ctrl_next = ssem_merge(ctrl_reg, wd_reg, ws_reg, SSEM_CTRL_MASK);
                SSEM_ADDR_RATE: if (ws_reg[0]) rate_next = wd_reg[7:0];
                SSEM_ADDR_TXDATA: ;
                default: br_next = SSEM_RESP_SLVERR;
            endcase
        end else if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (do_read) begin
            rv_next = 1'b1;
            rr_next = SSEM_RESP_OKAY;
            rd_next = 32'h0000_0000;
            case (s_axi_araddr)
                SSEM_ADDR_MODE:   rd_next = {16'h0000, mode_reg};
                SSEM_ADDR_CTRL:   rd_next = {16'h0000, ctrl_reg};
                SSEM_ADDR_RATE:   rd_next = {24'h000000, rate_reg};
                SSEM_ADDR_STATUS: rd_next = {28'h0000000, st_reg != SSEM_IDLE, ovr_reg, rxfull_reg, !txfull_reg};
                SSEM_ADDR_RXDATA: rd_next = {24'h000000, rxbuf_reg};
                SSEM_ADDR_TXDATA: ;
                default:          rr_next = SSEM_RESP_SLVERR;
            endcase
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
        // ready flags registered; write side stays shut while a response waits
        awrdy_next = !aw_next && !bv_next;
        wrdy_next  = !w_next && !bv_next;
        ardy_next  = !rv_next;
    end

    // shifter side: single byte holding stage, no fifo
    always_comb begin
        txbuf_next  = txbuf_reg;
        txfull_next = txfull_reg;
        rxbuf_next  = rxbuf_reg;
        rxfull_next = rxfull_reg;
        ovr_next    = ovr_reg;
        st_next     = st_reg;
        sh_next     = sh_reg;
        rsh_next    = rsh_reg;
        bit_next    = bit_reg;
        sck_next    = sck_reg;
        txd_next    = txd_reg;
        if (rx_take) begin
            rxfull_next = 1'b0;
            ovr_next    = 1'b0;
        end
        if (!tx_path_on || !sync_mode || !int_clock) begin
            // stop clean, clock idles high; txd keeps its last bit
            st_next  = SSEM_IDLE;
            sck_next = 1'b1;
        end else begin
            case (st_reg)
                SSEM_IDLE: begin
                    sck_next = 1'b1;
                    if (txfull_reg) begin
                        sh_next     = txbuf_reg;
                        txfull_next = 1'b0;
                        bit_next    = 3'h0;
                        st_next     = SSEM_LOW;
                    end
                end
                SSEM_LOW: if (tick) begin
                    // falling edge: drive next bit, msb first; parity never added
                    sck_next = 1'b0;
                    txd_next = sh_reg[SSEM_BYTE_BITS-1];
                    sh_next  = {sh_reg[6:0], 1'b0};
                    st_next  = SSEM_HIGH;
                end
                SSEM_HIGH: if (tick) begin
                    sck_next = 1'b1;
                    rsh_next = {rsh_reg[6:0], rxd};
                    bit_next = bit_reg + 3'h1;
                    // fixed eight bits, length/parity/stop settings unused
                    if (bit_reg == 3'h7) begin
                        st_next = SSEM_IDLE;
                        if (rx_path_on) begin
                            rxbuf_next  = {rsh_reg[6:0], rxd};
                            rxfull_next = 1'b1;
                            ovr_next    = ovr_next | (rxfull_reg && !rx_take);
                        end
                    end else begin
                        st_next = SSEM_LOW;
                    end
                end
                default: st_next = SSEM_IDLE;
            endcase
        end
        // after the take, so a write landing on it is not lost
        if (do_write && awa_reg == SSEM_ADDR_TXDATA && ws_reg[0]) begin
            txbuf_next  = wd_reg[7:0];
            txfull_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg   <= SSEM_MODE_RESET;
            ctrl_reg   <= SSEM_CTRL_RESET;
            rate_reg   <= SSEM_RATE_RESET;
            txbuf_reg  <= 8'h00;
            txfull_reg <= 1'b0;
            rxbuf_reg  <= 8'h00;
            rxfull_reg <= 1'b0;
            ovr_reg    <= 1'b0;
            st_reg     <= SSEM_IDLE;
            sh_reg     <= 8'h00;
            rsh_reg    <= 8'h00;
            bit_reg    <= 3'h0;
            sck_reg    <= 1'b1;
            txd_reg    <= 1'b1;
            aw_reg     <= 1'b0;
            awa_reg    <= 5'h00;
            w_reg      <= 1'b0;
            wd_reg     <= 32'h0000_0000;
            ws_reg     <= 4'h0;
            bv_reg     <= 1'b0;
            br_reg     <= 2'b00;
            rv_reg     <= 1'b0;
            rd_reg     <= 32'h0000_0000;
            rr_reg     <= 2'b00;
            awrdy_reg  <= 1'b1;
            wrdy_reg   <= 1'b1;
            ardy_reg   <= 1'b1;
        end else begin
            mode_reg   <= mode_next;
            ctrl_reg   <= ctrl_next;
            rate_reg   <= rate_next;
            txbuf_reg  <= txbuf_next;
            txfull_reg <= txfull_next;
            rxbuf_reg  <= rxbuf_next;
            rxfull_reg <= rxfull_next;
            ovr_reg    <= ovr_next;
            st_reg     <= st_next;
            sh_reg     <= sh_next;
            rsh_reg    <= rsh_next;
            bit_reg    <= bit_next;
            sck_reg    <= sck_next;
            txd_reg    <= txd_next;
            aw_reg     <= aw_next;
            awa_reg    <= awa_next;
            w_reg      <= w_next;
            wd_reg     <= wd_next;
            ws_reg     <= ws_next;
            bv_reg     <= bv_next;
            br_reg     <= br_next;
            rv_reg     <= rv_next;
            rd_reg     <= rd_next;
            rr_reg     <= rr_next;
            awrdy_reg  <= awrdy_next;
            wrdy_reg   <= wrdy_next;
            ardy_reg   <= ardy_next;
        end
    end

    // sck_in is never looked at: only internal clock is supported
    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready  = wrdy_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = ardy_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;
    assign sck_out       = sck_reg;
    assign txd           = txd_reg;
endmodule
`default_nettype wire

// File: verification/ssem_assertions.sv
`default_nettype none
module ssem_assertions
    import ssem_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [4:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sck_out,
    input wire logic        txd
);
    timeunit 1ns;
    timeprecision 1ns;
    // address of the read in flight, so rdata can be judged
    logic [4:0] ar_reg;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_reg <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_reserved_zero: assert property (
        s_axi_rvalid && (ar_reg == SSEM_ADDR_MODE || ar_reg == SSEM_ADDR_CTRL)
        |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[2])
        else $error("reserved bits not zero");
    a_unmapped_err: assert property (
        s_axi_rvalid && (ar_reg > SSEM_ADDR_RXDATA || ar_reg[1:0] != 2'h0) |-> s_axi_rresp == SSEM_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_txd_on_fall: assert property ($changed(txd) |-> $fell(sck_out))
        else $error("data changed off a falling clock");
endmodule
bind ssem_top ssem_assertions i_ssem_assertions (.*);
`default_nettype wire

// File: verification/ssem_eeprom_model.sv
`default_nettype none
module ssem_eeprom_model (
    input  wire logic       sel_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic [7:0]      heard
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] idx = 3'h0;
    logic       bit_q = 1'b0;
    // select arrives on its own port line, never from the channel
    always @(negedge sck or posedge sel_n) begin
        if (sel_n) begin
            idx <= 3'h0;
            bit_q <= ~bit_q;
        end else begin
            bit_q <= reply[3'h7 - idx];
            idx <= idx + 3'h1;
        end
    end
    // pull-up wins once deselected
    assign miso = sel_n ? 1'b1 : bit_q;
    always @(posedge sck) begin
        if (!sel_n) begin
            // msb arrives first, so no byte reversal is needed here
            heard <= {heard[6:0], mosi};
        end
    end
endmodule
`default_nettype wire

// File: verification/ssem_tb_top.sv
`default_nettype none
module ssem_tb_top
    import ssem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00;
    logic [4:0]  s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sck_in = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        sck_out, txd, rxd;
    logic        sel_n = 1'b1;
    logic        sck_q = 1'b1;
    logic [7:0]  reply = 8'h00;
    logic [7:0]  heard, rb;
    int          err_total = 0, checks_done = 0, falls = 0, lows = 0;
    ssem_top i_ssem_top (.*);
    ssem_eeprom_model i_ssem_eeprom_model (.sel_n(sel_n), .sck(sck_out), .mosi(txd), .reply(reply),
        .miso(rxd), .heard(heard));
    initial forever #50 aclk = ~aclk;
    // noise on the clock pin must not matter
    always @(posedge aclk) sck_in <= ~sck_in;
    always @(posedge aclk) begin
        if (sck_q && !sck_out) falls++;
        if (!sck_out) lows++;
        sck_q <= sck_out;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    // data only judged on okay; refused reads return zero but are not checked
    task automatic rdc(input string n, input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({n, " resp"}, {30'h0, s_axi_rresp}, {30'h0, er});
        if (er == SSEM_RESP_OKAY) chk(n, s_axi_rdata, ed);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rsp, input int half);
        reply = rsp;
        falls = 0;
        lows = 0;
        @(posedge aclk);
        sel_n <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(SSEM_ADDR_TXDATA, {24'h0, tx}, SSEM_RESP_OKAY);
        while (falls < 8) @(posedge aclk);
        do @(posedge aclk); while (sck_out !== 1'b1);
        repeat (4) @(posedge aclk);
        chk("eeprom heard", {24'h0, heard}, {24'h0, tx});
        chk("clock pulses", 32'(falls), 32'h8);
        chk("clock low time", 32'(lows), 32'(8 * half));
        sel_n <= 1'b1;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("mode reset", SSEM_ADDR_MODE, SSEM_MODE_RESET, SSEM_RESP_OKAY);
        rdc("rate reset", SSEM_ADDR_RATE, 32'h000000ff, SSEM_RESP_OKAY);
        wr(SSEM_ADDR_MODE, 32'hffffffff, SSEM_RESP_OKAY);
        rdc("mode mask", SSEM_ADDR_MODE, 32'h000000fb, SSEM_RESP_OKAY);
        wr(SSEM_ADDR_CTRL, 32'hffffffff, SSEM_RESP_OKAY);
        rdc("ctrl mask", SSEM_ADDR_CTRL, 32'h000000fb, SSEM_RESP_OKAY);
        wr(5'h18, 32'h000000a5, SSEM_RESP_SLVERR);
        rdc("unmapped", 5'h18, 32'h0, SSEM_RESP_SLVERR);
        wr(SSEM_ADDR_STATUS, 32'h0, SSEM_RESP_SLVERR);
        wr(SSEM_ADDR_RATE, 32'h00000001, SSEM_RESP_OKAY);
        wr(SSEM_ADDR_CTRL, 32'h00000030, SSEM_RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            rb = 8'h3c + 8'(k);
            // length, parity, odd and stop all set to prove they are ignored
            wr(SSEM_ADDR_MODE, 32'hf8 | 32'(k), SSEM_RESP_OKAY);
            xfer(8'ha5 ^ 8'(k), rb, 2 << (2 * k));
            rdc("status full", SSEM_ADDR_STATUS, 32'h00000003, SSEM_RESP_OKAY);
            rdc("rx byte", SSEM_ADDR_RXDATA, {24'h0, rb}, SSEM_RESP_OKAY);
        end
        xfer(8'h5a, 8'hc3, 128);
        xfer(8'h3c, 8'h96, 128);
        rdc("status overrun", SSEM_ADDR_STATUS, 32'h00000007, SSEM_RESP_OKAY);
        rdc("rx latest", SSEM_ADDR_RXDATA, 32'h00000096, SSEM_RESP_OKAY);
        wr(SSEM_ADDR_CTRL, 32'h00000020, SSEM_RESP_OKAY);
        xfer(8'h81, 8'h7e, 128);
        rdc("status tx only", SSEM_ADDR_STATUS, 32'h00000001, SSEM_RESP_OKAY);
        wr(SSEM_ADDR_MODE, 32'h00000078, SSEM_RESP_OKAY);
        falls = 0;
        wr(SSEM_ADDR_TXDATA, 32'h00000042, SSEM_RESP_OKAY);
        repeat (600) @(posedge aclk);
        chk("async no clock", 32'(falls), 32'h0);
        test_done();
    end
    initial begin
        repeat (40000) @(posedge aclk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
